// ===== verilog/wdt_pkg.sv
// wdt_pkg: register map, field positions and reset values of the two-stage watchdog
// assumes a 32-bit register port with word indices; shared by all wdt files except wdt_host_model
`default_nettype none
package wdt_pkg;
   localparam int unsigned WDT_AW          = 4;
   localparam int unsigned WDT_DW          = 32;
   // register indices
   localparam logic [3:0]  WDT_A_LOAD      = 4'h0;
   localparam logic [3:0]  WDT_A_VALUE     = 4'h1;
   localparam logic [3:0]  WDT_A_CTRL      = 4'h2;
   localparam logic [3:0]  WDT_A_ICLR      = 4'h3;
   localparam logic [3:0]  WDT_A_RIS       = 4'h4;
   localparam logic [3:0]  WDT_A_MIS       = 4'h5;
   localparam logic [3:0]  WDT_A_LOCK      = 4'h6;
   localparam logic [3:0]  WDT_A_ISTAT     = 4'h7;
   localparam logic [3:0]  WDT_A_IMASK     = 4'h8;
   // control field positions
   localparam int unsigned WDT_C_EN        = 0;
   localparam int unsigned WDT_C_RSTEN     = 1;
   localparam int unsigned WDT_C_STALL     = 2;
   // event status bit positions
   localparam int unsigned WDT_EV_FIRST    = 0;
   localparam int unsigned WDT_EV_SECOND   = 1;
   localparam int unsigned WDT_EV_NUM      = 2;
   // unlock key written to the lock register; any other value locks
   localparam logic [31:0] WDT_UNLOCK_KEY  = 32'h1ACC_E551;
   localparam logic [31:0] WDT_LOAD_RST    = 32'hFFFF_FFFF;
   localparam logic [31:0] WDT_ZERO        = 32'h0000_0000;
   localparam logic [31:0] WDT_ONE         = 32'h0000_0001;
   typedef enum logic [2:0] {
      WDT_IDLE  = 3'b001,
      WDT_ARMED = 3'b010,
      WDT_BITE  = 3'b100
   } wdt_state_e;
endpackage : wdt_pkg
`default_nettype wire

// ===== verilog/wdt_counter.sv
// wdt_counter: 32-bit down counter with load, hold and zero flag
// assumes single clock, async active-high reset
`default_nettype none
module wdt_counter
   import wdt_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        load,
   input  wire logic [31:0] load_val,
   input  wire logic        run,
   output logic      [31:0] count,
   output logic             zero_hit
);
   logic [31:0] count_r;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= WDT_LOAD_RST;
      end else if (load) begin
         count_r <= load_val;
      end else if (run && count_r != WDT_ZERO) begin
         count_r <= count_r - WDT_ONE;
      end
   end

   assign count    = count_r;
   // next tick reaches zero; load is left out here so the parent's reload mux
   // can depend on this flag without forming a combinational loop
   assign zero_hit = run && (count_r == WDT_ONE);
endmodule : wdt_counter
`default_nettype wire

// ===== verilog/wdt_irq.sv
// wdt_irq: sticky event status, write-one-to-clear, mask and level interrupt
// assumes events are one-cycle pulses in the clk_sys domain
`default_nettype none
module wdt_irq
   import wdt_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic [WDT_EV_NUM-1:0] ev_set,
   input  wire logic [WDT_EV_NUM-1:0] ev_clr,
   input  wire logic [WDT_EV_NUM-1:0] ev_mask,
   output logic      [WDT_EV_NUM-1:0] ev_stat,
   output logic                       irq
);
   logic [WDT_EV_NUM-1:0] stat_r;

   genvar g;
   generate
      for (g = 0; g < WDT_EV_NUM; g++) begin : g_ev
         // set beats clear in the same cycle
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               stat_r[g] <= 1'b0;
            end else if (ev_set[g]) begin
               stat_r[g] <= 1'b1;
            end else if (ev_clr[g]) begin
               stat_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign ev_stat = stat_r;
   assign irq     = |(stat_r & ev_mask);
endmodule : wdt_irq
`default_nettype wire

// ===== verilog/wdt_top.sv
// wdt_top: two-stage watchdog timer with register port, lock and system reset request
// assumes a simple single-cycle register master on clk_sys; dbg_halt synchronous
//
// Summary of operation
// [RULE1] The block holds a 32-bit down counter, a load register, interrupt logic and a lock.
// [RULE2] While locked, writes to load and control registers are ignored.
// [RULE3] Setting the enable bit starts the counter and enables the timeout interrupt together.
// [RULE4] The first time the enabled counter reaches zero the timeout interrupt is raised.
// [RULE5] After the first timeout the counter reloads from the load register and keeps counting.
// [RULE6] Reset on the second timeout is a separate software-selected option.
// [RULE7] A second zero with the interrupt uncleared and reset enabled asserts the reset output.
// [RULE8] Clearing the interrupt before the second zero reloads the counter and avoids reset.
// [RULE9] Writing a new load value while running loads it at once and counting continues.
// [RULE10] Writing the interrupt clear register drops the timeout interrupt.
// [RULE11] Software clears the interrupt early in its handler, since the clear may land late.
// [RULE12] Raw and masked timeout status are readable, 1 meaning active.
// [RULE13] Writing a load value of zero raises the timeout interrupt at once.
// [RULE14] With stalling enabled the counter holds while the processor is halted.
// [RULE15] The lock register reads 1 while locked and 0 otherwise.
// [RULE16] The timeout interrupt is a level until cleared and the counter value is readable.
//
// Added by the designer: the address map and the plain strobed port.
`default_nettype none
module wdt_top
   import wdt_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [WDT_AW-1:0] reg_addr,
   input  wire logic [WDT_DW-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [WDT_DW-1:0] reg_rdata,
   input  wire logic              dbg_halt,
   output logic                   wdt_irq,
   output logic                   evt_irq,
   output logic                   sys_reset_req
);
   logic [31:0]           load_r;
   logic                  en_r;
   logic                  rsten_r;
   logic                  stall_r;
   logic                  lock_r;
   logic                  tirq_r;
   logic                  rst_out_r;
   logic [WDT_EV_NUM-1:0] imask_r;
   logic [WDT_DW-1:0]     rdata_r;
   wdt_state_e            state_r;

   logic [31:0]           count;
   logic                  zero_hit;
   logic                  cnt_load;
   logic [31:0]           cnt_val;
   logic                  cnt_run;
   logic [WDT_EV_NUM-1:0] ev_set;
   logic [WDT_EV_NUM-1:0] ev_clr;
   logic [WDT_EV_NUM-1:0] ev_stat;

   logic wr_load;
   logic wr_ctrl;
   logic wr_iclr;
   logic wr_lock;
   logic wr_istat;
   logic wr_imask;
   logic first_to;
   logic second_to;
   logic expire;

   assign wr_load  = reg_wr && reg_addr == WDT_A_LOAD && !lock_r;   // [RULE2]
   assign wr_ctrl  = reg_wr && reg_addr == WDT_A_CTRL && !lock_r;   // [RULE2]
   assign wr_iclr  = reg_wr && reg_addr == WDT_A_ICLR;
   assign wr_lock  = reg_wr && reg_addr == WDT_A_LOCK;
   assign wr_istat = reg_wr && reg_addr == WDT_A_ISTAT;
   assign wr_imask = reg_wr && reg_addr == WDT_A_IMASK;

   // a same-cycle load write overrides the tick, so it is no expiry
   assign expire    = zero_hit && !wr_load;
   // expiry: counter at one about to tick, or a zero load while running
   assign first_to  = en_r && !tirq_r &&
                      (expire || (wr_load && reg_wdata == WDT_ZERO));   // [RULE4] [RULE13]
   assign second_to = en_r && tirq_r && expire && !wr_iclr;

   // halting the core freezes the count only when stalling is chosen
   assign cnt_run  = en_r && !(stall_r && dbg_halt);   // [RULE14]

   // reload on expiry, on clear, or on a fresh load value
   always_comb begin
      cnt_load = 1'b0;
      cnt_val  = load_r;
      if (wr_load) begin
         cnt_load = 1'b1;
         cnt_val  = reg_wdata;   // [RULE9]
      end else if (wr_ctrl && reg_wdata[WDT_C_EN] && !en_r) begin
         cnt_load = 1'b1;   // [RULE3]
      end else if (en_r && wr_iclr && tirq_r) begin
         cnt_load = 1'b1;   // [RULE8]
      end else if (zero_hit && en_r) begin
         cnt_load = 1'b1;   // [RULE5]
      end
   end

   wdt_counter u_cnt (   // [RULE1]
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .load     (cnt_load),
      .load_val (cnt_val),
      .run      (cnt_run),
      .count    (count),
      .zero_hit (zero_hit)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         load_r <= WDT_LOAD_RST;
      end else if (wr_load) begin
         load_r <= reg_wdata;
      end
   end

   // enable is sticky once set: only a system reset stops the watchdog
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         en_r    <= 1'b0;
         rsten_r <= 1'b0;
         stall_r <= 1'b0;
      end else if (wr_ctrl) begin
         en_r    <= en_r | reg_wdata[WDT_C_EN];   // [RULE3]
         rsten_r <= reg_wdata[WDT_C_RSTEN];       // [RULE6]
         stall_r <= reg_wdata[WDT_C_STALL];
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lock_r <= 1'b0;
      end else if (wr_lock) begin
         lock_r <= (reg_wdata != WDT_UNLOCK_KEY);
      end
   end

   // timeout interrupt level; a first expiry wins over a same-cycle clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tirq_r <= 1'b0;
      end else if (first_to) begin
         tirq_r <= 1'b1;   // [RULE4] [RULE16]
      end else if (wr_iclr) begin
         tirq_r <= 1'b0;   // [RULE10]
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= WDT_IDLE;
      end else begin
         unique case (state_r)
            WDT_IDLE: begin
               if (en_r) begin
                  state_r <= WDT_ARMED;
               end
            end
            WDT_ARMED: begin
               if (second_to && rsten_r) begin
                  state_r <= WDT_BITE;   // [RULE7]
               end
            end
            WDT_BITE: begin
               state_r <= WDT_BITE;
            end
            default: begin
               state_r <= WDT_IDLE;
            end
         endcase
      end
   end

   // reset request holds until the system reset clears the block
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rst_out_r <= 1'b0;
      end else if (second_to && rsten_r) begin
         rst_out_r <= 1'b1;   // [RULE7]
      end
   end

   assign ev_set[WDT_EV_FIRST]  = first_to;
   assign ev_set[WDT_EV_SECOND] = second_to;
   assign ev_clr = wr_istat ? reg_wdata[WDT_EV_NUM-1:0] : '0;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         imask_r <= '0;
      end else if (wr_imask) begin
         imask_r <= reg_wdata[WDT_EV_NUM-1:0];
      end
   end

   wdt_irq u_irq (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .ev_set  (ev_set),
      .ev_clr  (ev_clr),
      .ev_mask (imask_r),
      .ev_stat (ev_stat),
      .irq     (evt_irq)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            WDT_A_LOAD:  rdata_r <= load_r;
            WDT_A_VALUE: rdata_r <= count;                                // [RULE16]
            WDT_A_CTRL:  rdata_r <= {29'h0, stall_r, rsten_r, en_r};
            WDT_A_RIS:   rdata_r <= {31'h0, tirq_r};                      // [RULE12]
            WDT_A_MIS:   rdata_r <= {31'h0, tirq_r & en_r};               // [RULE12]
            WDT_A_LOCK:  rdata_r <= {31'h0, lock_r};                      // [RULE15]
            WDT_A_ISTAT: rdata_r <= {30'h0, ev_stat};
            WDT_A_IMASK: rdata_r <= {30'h0, imask_r};
            default:     rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign reg_rdata     = rdata_r;
   assign wdt_irq       = tirq_r & en_r;   // [RULE16]
   assign sys_reset_req = rst_out_r;
endmodule : wdt_top
`default_nettype wire

// ===== verif/wdt_top_checker.sv
// wdt_top_checker: port-level assertions for the two-stage watchdog
// assumes it is bound onto wdt_top, one clk_sys domain
`default_nettype none
module wdt_top_checker
   import wdt_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              sys_rst,
   input wire logic [WDT_AW-1:0] reg_addr,
   input wire logic [WDT_DW-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [WDT_DW-1:0] reg_rdata,
   input wire logic              dbg_halt,
   input wire logic              wdt_irq,
   input wire logic              evt_irq,
   input wire logic              sys_reset_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire logic clr_w = reg_wr && reg_addr == WDT_A_ICLR;
   sequence s_rd(logic [3:0] a); reg_rd && reg_addr == a; endsequence
   sequence s_lk; reg_wr && reg_addr == WDT_A_LOCK && reg_wdata != WDT_UNLOCK_KEY; endsequence
   property p_rd_idle; !reg_rd |=> reg_rdata == WDT_ZERO; endproperty
   property p_mis; s_rd(WDT_A_MIS) |=> reg_rdata == {31'h0, $past(wdt_irq)}; endproperty
   property p_ris; s_rd(WDT_A_RIS) |=> reg_rdata == {31'h0, $past(wdt_irq)}; endproperty
   property p_lock;
      s_lk ##1 !reg_wr ##1 s_rd(WDT_A_LOCK) |=> reg_rdata == WDT_ONE;
   endproperty
   property p_clr; clr_w && wdt_irq |=> !wdt_irq; endproperty
   property p_hold; wdt_irq && !clr_w |=> wdt_irq; endproperty
   property p_rst_hold; sys_reset_req |=> sys_reset_req; endproperty
   // a reset request without a pending timeout means a lost clear
   property p_rst_cause; $rose(sys_reset_req) |-> wdt_irq && $past(wdt_irq); endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_mis: assert property (p_mis) else $error("masked status wrong");
   a_ris: assert property (p_ris) else $error("raw status wrong");
   a_lock: assert property (p_lock) else $error("lock state wrong");
   a_clr: assert property (p_clr) else $error("clear did not drop irq");
   a_hold: assert property (p_hold) else $error("irq dropped uncleared");
   a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped");
   a_rst_cause: assert property (p_rst_cause) else $error("reset without timeout");
endmodule : wdt_top_checker
bind wdt_top wdt_top_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .dbg_halt(dbg_halt), .wdt_irq(wdt_irq), .evt_irq(evt_irq), .sys_reset_req(sys_reset_req));
`default_nettype wire

// ===== verif/wdt_host_model.sv
// wdt_host_model: processor interrupt input and system reset logic
// assumes level outputs of wdt_top sampled on clk_sys
`default_nettype none
module wdt_host_model (
   input  wire logic clk_sys,
   input  wire logic wdt_irq,
   input  wire logic sys_reset_req,
   output int        n_irq,
   output int        n_rst
);
   timeunit 1ns;
   timeprecision 1ns;
   logic irq_q, rst_q;
   initial begin
      n_irq = 0;
      n_rst = 0;
   end
   // levels: a held line is one request, so count rising edges only
   always @(posedge clk_sys) begin
      irq_q <= wdt_irq;
      rst_q <= sys_reset_req;
      if (wdt_irq && !irq_q) n_irq <= n_irq + 1;
      if (sys_reset_req && !rst_q) n_rst <= n_rst + 1;
   end
endmodule : wdt_host_model
`default_nettype wire

// ===== verif/wdt_top_tb.sv
// wdt_top_tb: self-checking bench for the two-stage watchdog
// assumes wdt_pkg, wdt_top, wdt_host_model and the bound checker
`default_nettype none
module wdt_top_tb
   import wdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk_sys, sys_rst, reg_wr, reg_rd, dbg_halt;
   logic              wdt_irq, evt_irq, sys_reset_req;
   logic [WDT_AW-1:0] reg_addr;
   logic [WDT_DW-1:0] reg_wdata, reg_rdata;
   int                fails, n_compared, n_irq, n_rst, n, nl, h;
   integer            seed;
   wdt_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dbg_halt(dbg_halt), .wdt_irq(wdt_irq), .evt_irq(evt_irq), .sys_reset_req(sys_reset_req));
   wdt_host_model u_host (.clk_sys(clk_sys), .wdt_irq(wdt_irq),
      .sys_reset_req(sys_reset_req), .n_irq(n_irq), .n_rst(n_rst));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic int rnd(input int lo, input int span);
      return lo + int'($unsigned($random(seed)) % span);
   endfunction : rnd
   // cycles from the reference edge to the expiry; each halted edge adds one, skip edges come off
   function automatic int exp_cyc(input int ld, input int hl, input int skip);
      return ld + hl - skip;
   endfunction : exp_cyc
   task summarize;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   // counts edges until irq or reset request; halts hl edges from the second
   task wt(input bit r, input int hl, output int k);
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
         if (k == 2 && hl > 0) dbg_halt <= 1'b1;
         if (k == 2 + hl) dbg_halt <= 1'b0;
         #1;
      end while ((r ? sys_reset_req : wdt_irq) !== 1'b1 && k < 5000);
   endtask : wt
   task do_rst;
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
   endtask : do_rst
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      seed = 32'h66DE;
      {sys_rst, reg_wr, reg_rd, dbg_halt} = 4'h8;
      reg_addr = 4'h0;
      reg_wdata = WDT_ZERO;
      do_rst();
      rd(WDT_A_LOAD, WDT_LOAD_RST);
      rd(WDT_A_VALUE, WDT_LOAD_RST);
      rd(4'hC, WDT_ZERO);
      wr(WDT_A_LOCK, WDT_ZERO);
      rd(WDT_A_LOCK, WDT_ONE);
      wr(WDT_A_LOAD, 32'h0000_0010);
      wr(WDT_A_CTRL, 32'h0000_0007);
      rd(WDT_A_LOAD, WDT_LOAD_RST);
      rd(WDT_A_CTRL, WDT_ZERO);
      wr(WDT_A_LOCK, WDT_UNLOCK_KEY);
      rd(WDT_A_LOCK, WDT_ZERO);
      $display("test lock done");
      // long load so the register traffic below ends before the next expiry
      nl = rnd(40, 32);
      wr(WDT_A_LOAD, nl);
      wr(WDT_A_CTRL, WDT_ONE);
      wt(0, rnd(1, 6), n);
      chk(n, exp_cyc(nl, 0, 0));
      repeat (nl + 2) @(posedge clk_sys);
      #1;
      chk(sys_reset_req, 1'b0);
      rd(WDT_A_ISTAT, 32'h0000_0003);
      wr(WDT_A_IMASK, 32'h0000_0002);
      #1;
      chk(evt_irq, 1'b1);
      wr(WDT_A_IMASK, WDT_ZERO);
      #1;
      chk(evt_irq, 1'b0);
      wr(WDT_A_ISTAT, 32'h0000_0003);
      rd(WDT_A_ISTAT, WDT_ZERO);
      wr(WDT_A_ICLR, WDT_ONE);
      #1;
      chk(wdt_irq, 1'b0);
      wt(0, 0, n);
      chk(n, exp_cyc(nl, 0, 0));
      wr(WDT_A_ICLR, WDT_ONE);
      h = rnd(8, 24);
      wr(WDT_A_LOAD, h);
      wt(0, 0, n);
      chk(n, exp_cyc(h, 0, 0));
      wr(WDT_A_ICLR, WDT_ONE);
      wr(WDT_A_LOAD, WDT_ZERO);
      wt(0, 0, n);
      chk(n, 1);
      $display("test interrupt done");
      do_rst();
      nl = rnd(8, 32);
      wr(WDT_A_LOAD, nl);
      wr(WDT_A_CTRL, 32'h0000_0003);
      wt(0, 0, n);
      chk(n, exp_cyc(nl, 0, 0));
      wt(1, 0, n);
      chk(n, exp_cyc(nl, 0, 0));
      rd(WDT_A_RIS, WDT_ONE);
      rd(WDT_A_MIS, WDT_ONE);
      chk(n_rst, 1);
      chk(n_irq, 5);
      $display("test reset done");
      do_rst();
      nl = rnd(8, 32);
      h = rnd(1, 8);
      wr(WDT_A_LOAD, nl);
      wr(WDT_A_CTRL, 32'h0000_0005);
      rd(WDT_A_VALUE, nl - 1);
      wt(0, h, n);
      chk(n, exp_cyc(nl, h, 2));
      $display("test stall done");
      summarize();
   end
endmodule : wdt_top_tb
`default_nettype wire
